// ==== verilog/mcg_pkg.sv ====
package mcg_pkg;
  // ****************************************
  // Sizes and timing
  // ****************************************
  localparam int CLKS_PER_CYCLE = 4;
  localparam int NPORTS = 5;
  localparam int PW = 8;
  localparam int USB_CAUSES = 27;
  localparam int NIRQ = 13;
  localparam int RAM_BYTES = 256;
  localparam int AVEC_SHIFT = 2;
  // ****************************************
  // Memory map of the core
  // ****************************************
  localparam logic [7:0] RAM_DIRECT_TOP = 8'h7F;
  localparam logic [15:0] PROG_TOP_RST = 16'h1FFF;
  localparam logic [15:0] PERIPH_LO = 16'hE400;
  localparam logic [15:0] PERIPH_HI = 16'hFFFF;
  // ****************************************
  // APB register indices (byte address = 4 * index)
  // ****************************************
  localparam logic [3:0] REG_DIR_A = 4'h0;
  localparam logic [3:0] REG_DATA_A = 4'h5;
  localparam logic [3:0] REG_ALT_E = 4'hA;
  localparam logic [3:0] REG_USB_PEND = 4'hB;
  localparam logic [3:0] REG_USB_EN = 4'hC;
  localparam logic [3:0] REG_AVEC = 4'hD;
  localparam logic [3:0] REG_IRQ_STAT = 4'hE;
  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int PORT_A = 0;
  localparam int PORT_E = 4;
  localparam int T2_ALT_BIT = 2;
  localparam int EXTERNAL_IRQ_ZERO_BIT = 0;
  localparam int EXTERNAL_IRQ_ONE_BIT = 1;
  localparam int AVEC_EN_BIT = 0;
  localparam logic [7:0] DIR_RST = 8'h00;
  localparam logic [7:0] ALT_RST = 8'h00;
  // Interrupt priority slots
  localparam int SLOT_RESUME = 0;
  localparam int SLOT_EXTERNAL_IRQ_ZERO = 1;
  localparam int SLOT_T0 = 2;
  localparam int SLOT_EXTERNAL_IRQ_ONE = 3;
  localparam int SLOT_T1 = 4;
  localparam int SLOT_SER0 = 5;
  localparam int SLOT_T2 = 6;
  localparam int SLOT_SER1 = 7;
  localparam int SLOT_USB = 8;
  localparam int SLOT_TWI = 9;
  localparam int SLOT_WAVE = 10;
  localparam int SLOT_EXTERNAL_IRQ_FIVE = 11;
  localparam int SLOT_EXTERNAL_IRQ_SIX = 12;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    PH0 = 2'b00,
    PH1 = 2'b01,
    PH2 = 2'b10,
    PH3 = 2'b11
  } mcg_phase_type;
  typedef struct packed {
    mcg_phase_type phase;
    logic bus_end;
    logic [RAM_BYTES-1:0][7:0] ram;
    logic [7:0] drdata;
    logic sfr_sel;
    logic x_onchip;
    logic x_periph;
    logic ext_rd_n;
    logic ext_wr_n;
    logic ext_cs_n;
    logic ext_oe_n;
    logic ext_program_store_strobe_n;
    logic [NPORTS-1:0][PW-1:0] dir;
    logic [NPORTS-1:0][PW-1:0] lat;
    logic [PW-1:0] alt_e;
    logic [NPORTS-1:0][PW-1:0] pout;
    logic [NPORTS-1:0][PW-1:0] poe_n;
    logic t2_prev;
    logic t2_pulse;
    logic [USB_CAUSES-1:0] pend;
    logic [USB_CAUSES-1:0] en;
    logic avec_en;
    logic avec_act;
    logic [7:0] avec_off;
    logic [NIRQ-1:0] irq;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } mcg_state_type;
endpackage : mcg_pkg

// ==== verilog/mcg_glue.sv ====
// How it works
// - instruction cycle lasts four clocks
// - direct 0x00-0x7F RAM, 0x80-0xFF registers
// - upper 128 RAM bytes reached indirectly only
// - peripheral window spans 0xE400 to 0xFFFF
// - on-chip memory reached by external moves
// - off-chip strobes fire only outside on-chip
// - standard instruction set, equivalent results
// - no serial framing or address compare registers
// - no timer 2 downcount, enable, mode register
// - timer 2 overflow output lasts one clock
// - port E alt bit 2 selects timer output
// - no timed access, watchdog or power fail
// - direction bit 0 input, 1 output
// - data writes drive outputs, reads see pins
// - alternate function overrides direction bit
// - reset leaves pins input, alternates off
// - thirteen interrupt sources in total
// - interrupt 4 is pin OR waveform logic
// - wakeup from dedicated or shared pin
// - fixed priority slots 0, 8, 9, 10, 11, 12
// - all USB causes share interrupt 2
// - dispatch replaces interrupt 2 jump target
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/100ps
module mcg_glue #(
  parameter logic [15:0] PROG_TOP = mcg_pkg::PROG_TOP_RST
) (
  input wire logic REF_CLK,
  input wire logic RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic PREADY,
  output logic [31:0] PRDATA,
  output logic PSLVERR,
  // Core internal data access
  input wire logic [7:0] CORE_DADDR,
  input wire logic CORE_DIND,
  input wire logic CORE_DRE,
  input wire logic CORE_DWE,
  input wire logic [7:0] CORE_DWDATA,
  output logic [7:0] CORE_DRDATA,
  output logic CORE_SFR_SEL,
  output logic BUS_CYCLE_END,
  // Core external data moves and fetches
  input wire logic [15:0] CORE_XADDR,
  input wire logic CORE_XRD,
  input wire logic CORE_XWR,
  input wire logic CORE_FETCH,
  output logic XMEM_ONCHIP,
  output logic XMEM_PERIPH,
  output logic EXT_RD_N,
  output logic EXT_WR_N,
  output logic EXT_CS_N,
  output logic EXT_OE_N,
  output logic EXT_PROGRAM_STORE_STROBE_N,
  // Port pins, five ports of eight
  input wire logic [mcg_pkg::NPORTS*mcg_pkg::PW-1:0] PIO_IN,
  output logic [mcg_pkg::NPORTS*mcg_pkg::PW-1:0] PIO_OUT,
  output logic [mcg_pkg::NPORTS*mcg_pkg::PW-1:0] PIO_OE_N,
  input wire logic [mcg_pkg::PW-1:0] ALT_E_OUT,
  input wire logic [mcg_pkg::PW-1:0] ALT_E_DRIVE,
  input wire logic T2_OVERFLOW,
  // Interrupt sources
  input wire logic USB_RESUME,
  input wire logic WAKEUP_PIN,
  input wire logic ALT_WAKEUP_PIN,
  input wire logic TIMER0_IRQ,
  input wire logic TIMER1_IRQ,
  input wire logic TIMER2_IRQ,
  input wire logic SERIAL0_IRQ,
  input wire logic SERIAL1_IRQ,
  input wire logic TWO_WIRE_IRQ,
  input wire logic WAVEFORM_IRQ,
  input wire logic EXT_IRQ4_PIN,
  input wire logic EXT_IRQ5_PIN,
  input wire logic EXT_IRQ6_PIN,
  input wire logic [mcg_pkg::USB_CAUSES-1:0] USB_CAUSE,
  output logic [mcg_pkg::NIRQ-1:0] IRQ_REQ,
  output logic AUTOVEC_ACTIVE,
  output logic [7:0] AUTOVEC_OFFSET
);
  import mcg_pkg::*;

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (PROG_TOP >= PERIPH_LO) begin : g_chk
    $error("Program RAM overlaps peripheral window");
  end

  // ****************************************
  // Decode helpers
  // ****************************************
  // Peripheral register and buffer window
  function automatic logic is_periph(input logic [15:0] a);
    is_periph = (a >= PERIPH_LO) && (a <= PERIPH_HI);
  endfunction : is_periph

  // Any address served inside the chip
  function automatic logic is_onchip(input logic [15:0] a);
    is_onchip = (a <= PROG_TOP) || is_periph(a);
  endfunction : is_onchip

  // Lowest pending enabled USB cause
  function automatic logic [4:0] first_cause(input logic [USB_CAUSES-1:0] v);
    first_cause = 5'h00;
    for (int i = USB_CAUSES - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_cause = 5'(i);
      end
    end
  endfunction : first_cause

  // Reset image of the whole state
  function automatic mcg_state_type reset_state();
    mcg_state_type r;
    r = '0;
    r.phase = PH0;
    r.ext_rd_n = 1'b1;
    r.ext_wr_n = 1'b1;
    r.ext_cs_n = 1'b1;
    r.ext_oe_n = 1'b1;
    r.ext_program_store_strobe_n = 1'b1;
    for (int p = 0; p < NPORTS; p++) begin
      r.dir[p] = DIR_RST;
      r.poe_n[p] = ~DIR_RST;
    end
    r.alt_e = ALT_RST;
    return r;
  endfunction : reset_state

  mcg_state_type s_q;
  mcg_state_type s_d;
  logic apb_done;
  logic apb_bad;
  logic [3:0] idx;
  logic [USB_CAUSES-1:0] live;
  logic wave_req;
  logic wake_req;
  logic xoff;
  logic [PW-1:0] pin_e;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    idx = PADDR[5:2];
    apb_done = PSEL & PENABLE & s_q.pready;
    // Unmapped, misaligned or absent registers answer with an error
    apb_bad = (PADDR[1:0] != 2'b00) || (PADDR[7:6] != 2'b00)
      || (idx > REG_IRQ_STAT);
    live = s_q.pend & s_q.en;
    wave_req = EXT_IRQ4_PIN | WAVEFORM_IRQ;
    wake_req = WAKEUP_PIN | ALT_WAKEUP_PIN | USB_RESUME;
    xoff = ~is_onchip(CORE_XADDR);
    pin_e = '0;

    // Four clock bus cycle
    case (s_q.phase)
      PH0: s_d.phase = PH1;
      PH1: s_d.phase = PH2;
      PH2: s_d.phase = PH3;
      PH3: s_d.phase = PH0;
      default: s_d.phase = PH0;
    endcase
    s_d.bus_end = (s_q.phase == PH3);

    // Internal data RAM and register space
    s_d.sfr_sel = ~CORE_DIND & CORE_DADDR[7] & (CORE_DRE | CORE_DWE);
    if (CORE_DIND || CORE_DADDR <= RAM_DIRECT_TOP) begin
      // Upper half is its own RAM when reached indirectly
      if (CORE_DWE) begin
        s_d.ram[CORE_DADDR] = CORE_DWDATA;
      end
      s_d.drdata = CORE_DRE ? s_q.ram[CORE_DADDR] : 8'h00;
    end else begin
      s_d.drdata = 8'h00;
    end

    // External data moves: strobes only outside on-chip space
    s_d.x_onchip = (CORE_XRD | CORE_XWR | CORE_FETCH) & ~xoff;
    s_d.x_periph = (CORE_XRD | CORE_XWR) & is_periph(CORE_XADDR);
    s_d.ext_rd_n = ~(CORE_XRD & xoff);
    s_d.ext_wr_n = ~(CORE_XWR & xoff);
    s_d.ext_oe_n = ~((CORE_XRD | CORE_FETCH) & xoff);
    s_d.ext_program_store_strobe_n = ~(CORE_FETCH & xoff);
    s_d.ext_cs_n = ~((CORE_XRD | CORE_XWR | CORE_FETCH) & xoff);

    // Timer 2 overflow becomes a single clock pulse
    s_d.t2_prev = T2_OVERFLOW;
    s_d.t2_pulse = T2_OVERFLOW & ~s_q.t2_prev;

    // Pin drivers from direction, latch and alternate selects
    for (int p = 0; p < NPORTS; p++) begin
      s_d.pout[p] = s_q.lat[p];
      s_d.poe_n[p] = ~s_q.dir[p];
    end
    for (int b = 0; b < PW; b++) begin
      if (s_q.alt_e[b]) begin
        if (b == T2_ALT_BIT) begin
          s_d.pout[PORT_E][b] = s_q.t2_pulse;
          s_d.poe_n[PORT_E][b] = 1'b0;
        end else begin
          s_d.pout[PORT_E][b] = ALT_E_OUT[b];
          s_d.poe_n[PORT_E][b] = ~ALT_E_DRIVE[b];
        end
      end
    end

    // USB causes: set beats clear
    s_d.pend = s_q.pend | USB_CAUSE;
    if (apb_done && PWRITE && !apb_bad && idx == REG_USB_PEND) begin
      s_d.pend = (s_q.pend & ~PWDATA[USB_CAUSES-1:0]) | USB_CAUSE;
    end

    // Dispatch offset for the interrupt 2 jump
    s_d.avec_act = s_q.avec_en & (|live);
    s_d.avec_off = {1'b0, first_cause(live), 2'b00};

    // Thirteen request lines in priority slot order
    s_d.irq = '0;
    s_d.irq[SLOT_RESUME] = wake_req;
    s_d.irq[SLOT_EXTERNAL_IRQ_ZERO] = PIO_IN[PORT_A * PW + EXTERNAL_IRQ_ZERO_BIT];
    s_d.irq[SLOT_T0] = TIMER0_IRQ;
    s_d.irq[SLOT_EXTERNAL_IRQ_ONE] = PIO_IN[PORT_A * PW + EXTERNAL_IRQ_ONE_BIT];
    s_d.irq[SLOT_T1] = TIMER1_IRQ;
    s_d.irq[SLOT_SER0] = SERIAL0_IRQ;
    s_d.irq[SLOT_T2] = TIMER2_IRQ;
    s_d.irq[SLOT_SER1] = SERIAL1_IRQ;
    s_d.irq[SLOT_USB] = |live;
    s_d.irq[SLOT_TWI] = TWO_WIRE_IRQ;
    s_d.irq[SLOT_WAVE] = wave_req;
    s_d.irq[SLOT_EXTERNAL_IRQ_FIVE] = EXT_IRQ5_PIN;
    s_d.irq[SLOT_EXTERNAL_IRQ_SIX] = EXT_IRQ6_PIN;

    // APB slave: one wait state, then ready
    s_d.pready = PSEL & PENABLE & ~s_q.pready;
    s_d.pslverr = PSEL & PENABLE & ~s_q.pready & apb_bad;
    s_d.prdata = 32'h0000_0000;
    if (PSEL && PENABLE && !s_q.pready && !PWRITE && !apb_bad) begin
      if (idx < REG_DATA_A) begin
        s_d.prdata[PW-1:0] = s_q.dir[idx - REG_DIR_A];
      end else if (idx < REG_ALT_E) begin
        // Reads show the pins whatever the direction
        pin_e = PIO_IN[(idx - REG_DATA_A) * PW +: PW];
        s_d.prdata[PW-1:0] = pin_e;
      end else begin
        case (idx)
          REG_ALT_E: s_d.prdata[PW-1:0] = s_q.alt_e;
          REG_USB_PEND: s_d.prdata[USB_CAUSES-1:0] = s_q.pend;
          REG_USB_EN: s_d.prdata[USB_CAUSES-1:0] = s_q.en;
          REG_AVEC: s_d.prdata[AVEC_EN_BIT] = s_q.avec_en;
          REG_IRQ_STAT: s_d.prdata[NIRQ-1:0] = s_q.irq;
          default: s_d.prdata = 32'h0000_0000;
        endcase
      end
    end
    if (apb_done && PWRITE && !apb_bad) begin
      if (idx < REG_DATA_A) begin
        s_d.dir[idx - REG_DIR_A] = PWDATA[PW-1:0];
      end else if (idx < REG_ALT_E) begin
        s_d.lat[idx - REG_DATA_A] = PWDATA[PW-1:0];
      end else begin
        case (idx)
          REG_ALT_E: s_d.alt_e = PWDATA[PW-1:0];
          REG_USB_EN: s_d.en = PWDATA[USB_CAUSES-1:0];
          REG_AVEC: s_d.avec_en = PWDATA[AVEC_EN_BIT];
          default: s_d.en = s_q.en;
        endcase
      end
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      s_q <= reset_state();
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs straight from the state
  // ****************************************
  assign PREADY = s_q.pready;
  assign PRDATA = s_q.prdata;
  assign PSLVERR = s_q.pslverr;
  assign CORE_DRDATA = s_q.drdata;
  assign CORE_SFR_SEL = s_q.sfr_sel;
  assign BUS_CYCLE_END = s_q.bus_end;
  assign XMEM_ONCHIP = s_q.x_onchip;
  assign XMEM_PERIPH = s_q.x_periph;
  assign EXT_RD_N = s_q.ext_rd_n;
  assign EXT_WR_N = s_q.ext_wr_n;
  assign EXT_CS_N = s_q.ext_cs_n;
  assign EXT_OE_N = s_q.ext_oe_n;
  assign EXT_PROGRAM_STORE_STROBE_N = s_q.ext_program_store_strobe_n;
  assign PIO_OUT = s_q.pout;
  assign PIO_OE_N = s_q.poe_n;
  assign IRQ_REQ = s_q.irq;
  assign AUTOVEC_ACTIVE = s_q.avec_act;
  assign AUTOVEC_OFFSET = s_q.avec_off;
endmodule : mcg_glue

// ==== testbench/mcg_pin_model.sv ====
`timescale 1ns/100ps
module mcg_pin_model (
  input wire logic [mcg_pkg::NPORTS*mcg_pkg::PW-1:0] pio_out,
  input wire logic [mcg_pkg::NPORTS*mcg_pkg::PW-1:0] pio_oe_n,
  input wire logic [mcg_pkg::NPORTS*mcg_pkg::PW-1:0] level,
  output logic [mcg_pkg::NPORTS*mcg_pkg::PW-1:0] pio_in
);
  import mcg_pkg::*;
  // ****
  // Pin wires: device level where driven, outside level elsewhere
  // ****
  assign pio_in = (pio_oe_n & level) | (~pio_oe_n & pio_out);
endmodule : mcg_pin_model

// ==== testbench/mcg_glue_monitor.sv ====
`timescale 1ns/100ps
module mcg_glue_monitor #(
  parameter logic [15:0] PROG_TOP = mcg_pkg::PROG_TOP_RST
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire logic [7:0] CORE_DADDR,
  input wire logic CORE_DIND,
  input wire logic CORE_DRE,
  input wire logic CORE_DWE,
  input wire logic [7:0] CORE_DRDATA,
  input wire logic CORE_SFR_SEL,
  input wire logic BUS_CYCLE_END,
  input wire logic [15:0] CORE_XADDR,
  input wire logic CORE_XRD,
  input wire logic XMEM_ONCHIP,
  input wire logic XMEM_PERIPH,
  input wire logic EXT_RD_N,
  input wire logic [mcg_pkg::NPORTS*mcg_pkg::PW-1:0] PIO_OUT,
  input wire logic [mcg_pkg::NPORTS*mcg_pkg::PW-1:0] PIO_OE_N,
  input wire logic USB_RESUME,
  input wire logic WAKEUP_PIN,
  input wire logic ALT_WAKEUP_PIN,
  input wire logic WAVEFORM_IRQ,
  input wire logic EXT_IRQ4_PIN,
  input wire logic EXT_IRQ6_PIN,
  input wire logic [mcg_pkg::NIRQ-1:0] IRQ_REQ
);
  import mcg_pkg::*;
  logic alt2_q;
  // ****
  // Checks
  // ****
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // Shadow of the timer bit of the port E alternate register
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      alt2_q <= 1'h0;
    end else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == {2'h0, REG_ALT_E, 2'h0}) begin
      alt2_q <= PWDATA[T2_ALT_BIT];
    end
  end
  chk_cycle_four: assert property (
    BUS_CYCLE_END |=> !BUS_CYCLE_END [*3] ##1 BUS_CYCLE_END) else $error("cycle length");
  chk_sfr_select: assert property (
    (CORE_DRE || CORE_DWE) && !CORE_DIND |=> CORE_SFR_SEL == $past(CORE_DADDR[7]))
    else $error("register select");
  chk_direct_high: assert property (
    CORE_DRE && !CORE_DIND && CORE_DADDR[7] |=> CORE_DRDATA == 8'h00) else $error("high read");
  chk_periph_hit: assert property (
    CORE_XRD && CORE_XADDR >= PERIPH_LO |=> XMEM_PERIPH && XMEM_ONCHIP) else $error("window");
  chk_offchip_read: assert property (
    CORE_XRD && CORE_XADDR > PROG_TOP && CORE_XADDR < PERIPH_LO |=> !EXT_RD_N && !XMEM_ONCHIP)
    else $error("off chip read");
  chk_onchip_quiet: assert property (
    CORE_XRD && (CORE_XADDR <= PROG_TOP || CORE_XADDR >= PERIPH_LO) |=> EXT_RD_N)
    else $error("strobe on chip");
  chk_t2_single: assert property (
    alt2_q && $past(alt2_q, 3) && PIO_OUT[34] |=> !PIO_OUT[34]) else $error("pulse width");
  chk_t2_drive: assert property (
    alt2_q && $past(alt2_q, 3) |-> !PIO_OE_N[34]) else $error("timer pin");
  chk_irq4_or: assert property (
    1 |=> IRQ_REQ[SLOT_WAVE] == $past(EXT_IRQ4_PIN || WAVEFORM_IRQ)) else $error("irq4");
  chk_wake_or: assert property (
    1 |=> IRQ_REQ[SLOT_RESUME] == $past(USB_RESUME || WAKEUP_PIN || ALT_WAKEUP_PIN))
    else $error("wakeup");
  chk_irq6_slot: assert property (
    1 |=> IRQ_REQ[SLOT_EXTERNAL_IRQ_SIX] == $past(EXT_IRQ6_PIN)) else $error("irq6 slot");
  cover property (BUS_CYCLE_END);
  cover property (XMEM_PERIPH);
  cover property (!EXT_RD_N);
  cover property (IRQ_REQ[SLOT_USB]);
endmodule : mcg_glue_monitor
bind mcg_glue mcg_glue_monitor #(.PROG_TOP(PROG_TOP)) i_mon (
  .REF_CLK(REF_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .CORE_DADDR(CORE_DADDR),
  .CORE_DIND(CORE_DIND), .CORE_DRE(CORE_DRE), .CORE_DWE(CORE_DWE),
  .CORE_DRDATA(CORE_DRDATA), .CORE_SFR_SEL(CORE_SFR_SEL), .BUS_CYCLE_END(BUS_CYCLE_END),
  .CORE_XADDR(CORE_XADDR), .CORE_XRD(CORE_XRD), .XMEM_ONCHIP(XMEM_ONCHIP),
  .XMEM_PERIPH(XMEM_PERIPH), .EXT_RD_N(EXT_RD_N), .PIO_OUT(PIO_OUT), .PIO_OE_N(PIO_OE_N),
  .USB_RESUME(USB_RESUME), .WAKEUP_PIN(WAKEUP_PIN), .ALT_WAKEUP_PIN(ALT_WAKEUP_PIN),
  .WAVEFORM_IRQ(WAVEFORM_IRQ), .EXT_IRQ4_PIN(EXT_IRQ4_PIN), .EXT_IRQ6_PIN(EXT_IRQ6_PIN),
  .IRQ_REQ(IRQ_REQ));

// ==== testbench/testbench.sv ====
`timescale 1ns/100ps
module testbench;
  import mcg_pkg::*;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, err;
  logic [7:0] paddr = 8'h00, daddr = 8'h00, dwd = 8'h00, drd, av_off;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic dind = 1'h0, dre = 1'h0, dwe = 1'h0, sfr, t2 = 1'h0;
  logic [2:0] xreq = 3'h0;
  logic [7:0] alt_o = 8'h00, alt_dr = 8'h00;
  logic onchip, periph, rd_n, wr_n, oe_n, cs_n, program_store_strobe_n, bend, av_act, hit;
  logic [15:0] xaddr = 16'h0;
  logic [39:0] lvl = 40'h0, pin, pout, poe_n;
  logic [12:0] src = 13'h0, irq;
  logic [26:0] cause = 27'h0;
  logic [3:0] hits;
  logic [15:0] xa [5] = '{16'h1FFF, 16'h2000, 16'hE3FF, 16'hE400, 16'hFFFF};
  int n_errors = 0, n_checks = 0, cycles = 0;
  localparam int SLOT [13] = '{0, 0, 0, 2, 4, 6, 5, 7, 9, 10, 10, 11, 12};
  // ****
  // Design, pins and clock
  // ****
  mcg_glue i_dut (.REF_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
    .CORE_DADDR(daddr), .CORE_DIND(dind), .CORE_DRE(dre), .CORE_DWE(dwe), .CORE_DWDATA(dwd),
    .CORE_DRDATA(drd), .CORE_SFR_SEL(sfr), .BUS_CYCLE_END(bend), .CORE_XADDR(xaddr),
    .CORE_XRD(xreq[0]), .CORE_XWR(xreq[1]), .CORE_FETCH(xreq[2]), .XMEM_ONCHIP(onchip),
    .XMEM_PERIPH(periph), .EXT_RD_N(rd_n), .EXT_WR_N(wr_n), .EXT_CS_N(cs_n), .EXT_OE_N(oe_n),
    .EXT_PROGRAM_STORE_STROBE_N(program_store_strobe_n), .PIO_IN(pin), .PIO_OUT(pout), .PIO_OE_N(poe_n), .ALT_E_OUT(alt_o),
    .ALT_E_DRIVE(alt_dr), .T2_OVERFLOW(t2), .USB_RESUME(src[0]), .WAKEUP_PIN(src[1]),
    .ALT_WAKEUP_PIN(src[2]), .TIMER0_IRQ(src[3]), .TIMER1_IRQ(src[4]), .TIMER2_IRQ(src[5]),
    .SERIAL0_IRQ(src[6]), .SERIAL1_IRQ(src[7]), .TWO_WIRE_IRQ(src[8]),
    .WAVEFORM_IRQ(src[9]), .EXT_IRQ4_PIN(src[10]), .EXT_IRQ5_PIN(src[11]),
    .EXT_IRQ6_PIN(src[12]), .USB_CAUSE(cause), .IRQ_REQ(irq), .AUTOVEC_ACTIVE(av_act),
    .AUTOVEC_OFFSET(av_off));
  mcg_pin_model i_pins (.pio_out(pout), .pio_oe_n(poe_n), .level(lvl), .pio_in(pin));
  always #2.5 clk = ~clk;
  // Cut a hung run short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One bus transfer: setup, access until ready, then an idle edge
  task automatic apb(input logic w, input logic [3:0] idx, input logic [31:0] wd);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask : apb
  task automatic rdc(input string nm, input logic [3:0] idx, input logic [31:0] exp);
    apb(1'h0, idx, 32'h0);
    chk(nm, rdat, exp);
  endtask : rdc
  task automatic core(input logic ind, input logic w, input logic [7:0] a, input logic [7:0] d);
    dind <= ind;
    dwe <= w;
    dre <= !w;
    daddr <= a;
    dwd <= d;
    @(posedge clk);
    dre <= 1'h0;
    dwe <= 1'h0;
    @(posedge clk);
  endtask : core
  // ****
  // Tests
  // ****
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    chk("pin enables", poe_n, '1);
    @(posedge clk);
    for (int p = 0; p < NPORTS; p++) rdc("direction", 4'(REG_DIR_A + p), 32'h0);
    rdc("alt config", REG_ALT_E, 32'h0);
    $display("reset test done");
    for (int i = 0; i < NIRQ; i++) begin
      src <= 13'h1 << i;
      repeat (2) @(posedge clk);
      chk("request", irq, 13'h1 << SLOT[i]);
    end
    src <= 13'h0;
    lvl[0] <= 1'h1;
    repeat (2) @(posedge clk);
    chk("request", irq, 13'h2);
    lvl <= {5{8'h3C}};
    hits = 4'h0;
    repeat (16) begin
      @(posedge clk);
      hits += bend;
    end
    chk("cycle ends", hits, 4'h4);
    $display("interrupt test done");
    for (int p = 0; p < NPORTS; p++) begin
      apb(1'h1, 4'(REG_DIR_A + p), 32'h0F);
      apb(1'h1, 4'(REG_DATA_A + p), 32'hA5);
    end
    repeat (3) @(posedge clk);
    chk("pin enables", poe_n, {5{8'hF0}});
    chk("pin out", pout & {5{8'h0F}}, {5{8'h05}});
    for (int p = 0; p < NPORTS; p++) rdc("pins", 4'(REG_DATA_A + p), 32'h35);
    alt_o <= 8'h08;
    alt_dr <= 8'h08;
    apb(1'h1, 4'(REG_DIR_A + PORT_E), 32'h0);
    apb(1'h1, REG_ALT_E, 32'hC);
    repeat (3) @(posedge clk);
    chk("alt pin enables", poe_n[35:34], 2'h0);
    chk("alt pin out", pout[35], 1'h1);
    t2 <= 1'h1;
    hits = 4'h0;
    repeat (8) begin
      @(posedge clk);
      hits += pout[34];
    end
    chk("overflow pulses", hits, 4'h1);
    t2 <= 1'h0;
    apb(1'h1, REG_ALT_E, 32'h0);
    repeat (3) @(posedge clk);
    chk("alt pin enables", poe_n[35:34], 2'h3);
    $display("port test done");
    core(1'h0, 1'h1, 8'h10, 8'h5A);
    core(1'h1, 1'h1, 8'h90, 8'hC3);
    core(1'h0, 1'h1, 8'h90, 8'h11);
    core(1'h0, 1'h0, 8'h90, 8'h00);
    chk("direct high read", {sfr, drd}, {1'h1, 8'h00});
    core(1'h1, 1'h0, 8'h90, 8'h00);
    chk("indirect read", {sfr, drd}, {1'h0, 8'hC3});
    core(1'h0, 1'h0, 8'h10, 8'h00);
    chk("direct read", drd, 8'h5A);
    // Read, write and fetch in turn at each address
    foreach (xa[k]) begin
      for (int m = 0; m < 3; m++) begin
        xaddr <= xa[k];
        xreq <= 3'(1 << m);
        @(posedge clk);
        xreq <= 3'h0;
        @(posedge clk);
        hit = xa[k] <= PROG_TOP_RST || xa[k] >= PERIPH_LO;
        chk("on chip", onchip, hit);
        chk("window", periph, m < 2 && xa[k] >= PERIPH_LO);
        chk("strobes", {rd_n, wr_n, oe_n, program_store_strobe_n, cs_n},
          {m != 0 || hit, m != 1 || hit, m == 1 || hit, m != 2 || hit, hit});
      end
    end
    $display("memory test done");
    cause <= 27'h220;
    @(posedge clk);
    cause <= 27'h0;
    apb(1'h1, REG_USB_EN, 32'h20);
    rdc("pending", REG_USB_PEND, 32'h220);
    chk("usb request", irq[8], 1'h1);
    apb(1'h1, REG_AVEC, 32'h1);
    repeat (2) @(posedge clk);
    chk("dispatch", {av_act, av_off}, {1'h1, 8'(5 << AVEC_SHIFT)});
    apb(1'h1, REG_USB_PEND, 32'h20);
    rdc("pending", REG_USB_PEND, 32'h200);
    chk("usb request", irq[8], 1'h0);
    apb(1'h0, 4'hF, 32'h0);
    chk("unmapped", {err, rdat}, {1'h1, 32'h0});
    $display("usb test done");
    close_out();
  end
endmodule : testbench
